// [lcd_cmd_defines.svh]
// reset values, opcodes and limits of the command interpreter
// assumes inclusion by the design modules only; the package does not include it
`ifndef LCD_CMD_DEFINES_SVH
`define LCD_CMD_DEFINES_SVH

// reset values
`define RST_COLUMN 8'h00
`define RST_GAIN 3'h4
`define RST_POWER 3'h0
`define RST_START_LINE 6'h00
`define RST_CONTRAST 6'h20
`define RST_PAGE 4'h0

// limits
`define PAGE_LAST 4'h8
`define COLUMN_LAST 8'h83

// opcode fields
`define NIB_COL_LO 4'h0
`define NIB_COL_HI 4'h1
`define PFX5_GAIN 5'h04
`define PFX5_POWER 5'h05
`define PFX2_START 2'h1
`define OP_CONTRAST 8'h81
`define PFX7_SEG_REMAP 7'h50
`define PFX7_BIAS 7'h51
`define PFX7_ALL_ON 7'h52
`define PFX7_REVERSE 7'h53
`define PFX7_DISP_ON 7'h57
`define NIB_PAGE 4'hb
`define NIB_COM_DIR 4'hc
`define OP_RMW_ENTER 8'he0
`define OP_SOFT_RESET 8'he2
`define OP_RMW_EXIT 8'hee

`endif

// [lcd_cmd_pkg.sv]
// types shared by the command interpreter modules
// assumes lcd_cmd_defines.svh is on the include path
package lcd_cmd_pkg;

    typedef enum logic [4:0] {
        CMD_NONE = 5'b00000,
        CMD_COL_LO = 5'b00001,
        CMD_COL_HI = 5'b00010,
        CMD_GAIN = 5'b00011,
        CMD_POWER = 5'b00100,
        CMD_START = 5'b00101,
        CMD_CONTRAST = 5'b00110,
        CMD_SEG_REMAP = 5'b00111,
        CMD_BIAS = 5'b01000,
        CMD_ALL_ON = 5'b01001,
        CMD_REVERSE = 5'b01010,
        CMD_DISP_ON = 5'b01011,
        CMD_PAGE = 5'b01100,
        CMD_COM_DIR = 5'b01101,
        CMD_RMW_ENTER = 5'b01110,
        CMD_RMW_EXIT = 5'b01111,
        CMD_SOFT_RESET = 5'b10000
    } cmd_kind_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT_CONTRAST = 1'b1
    } cmd_state_t;

    typedef struct packed {
        logic [3:0] page_address;
        logic [5:0] start_line;
        logic [5:0] contrast_level;
        logic [2:0] regulator_gain_select;
        logic [2:0] power_enable_bits;
        logic seg_remap;
        logic bias_alt;
        logic entire_on;
        logic reverse_video;
        logic display_on;
        logic com_reverse;
    } display_state_t;

endpackage

// [cmd_byte_decode.sv]
// classifies one command byte into a command kind
// assumes the byte is a command (data/command select low)
`timescale 1ns/1ps
`include "lcd_cmd_defines.svh"
module cmd_byte_decode
    import lcd_cmd_pkg::*;
(
    // command byte in
    input wire logic [7:0] cmd_byte,
    // classification out
    output cmd_kind_t cmd_kind
);
    wire is_col_lo = (cmd_byte[7:4] == `NIB_COL_LO);
    wire is_col_hi = (cmd_byte[7:4] == `NIB_COL_HI);
    wire is_gain = (cmd_byte[7:3] == `PFX5_GAIN);
    wire is_power = (cmd_byte[7:3] == `PFX5_POWER);
    wire is_start = (cmd_byte[7:6] == `PFX2_START);
    wire is_contrast = (cmd_byte == `OP_CONTRAST);
    wire is_remap = (cmd_byte[7:1] == `PFX7_SEG_REMAP);
    wire is_bias = (cmd_byte[7:1] == `PFX7_BIAS);
    wire is_all_on = (cmd_byte[7:1] == `PFX7_ALL_ON);
    wire is_reverse = (cmd_byte[7:1] == `PFX7_REVERSE);
    wire is_disp_on = (cmd_byte[7:1] == `PFX7_DISP_ON);
    wire is_page = (cmd_byte[7:4] == `NIB_PAGE);
    wire is_com_dir = (cmd_byte[7:4] == `NIB_COM_DIR);
    wire is_rmw_in = (cmd_byte == `OP_RMW_ENTER);
    wire is_rmw_out = (cmd_byte == `OP_RMW_EXIT);
    wire is_sreset = (cmd_byte == `OP_SOFT_RESET);

    // bytes outside this set (extended, indicator, nop, test) fall to none
    assign cmd_kind = is_col_lo ? CMD_COL_LO :
                      is_col_hi ? CMD_COL_HI :
                      is_gain ? CMD_GAIN :
                      is_power ? CMD_POWER :
                      is_start ? CMD_START :
                      is_contrast ? CMD_CONTRAST :
                      is_remap ? CMD_SEG_REMAP :
                      is_bias ? CMD_BIAS :
                      is_all_on ? CMD_ALL_ON :
                      is_reverse ? CMD_REVERSE :
                      is_disp_on ? CMD_DISP_ON :
                      is_page ? CMD_PAGE :
                      is_com_dir ? CMD_COM_DIR :
                      is_rmw_in ? CMD_RMW_ENTER :
                      is_rmw_out ? CMD_RMW_EXIT :
                      is_sreset ? CMD_SOFT_RESET : CMD_NONE;
endmodule // cmd_byte_decode

// [column_addr_unit.sv]
// column address with nibble loads, auto advance and read-modify-write save
// assumes one-cycle strobes from the command interpreter
`timescale 1ns/1ps
`include "lcd_cmd_defines.svh"
module column_addr_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controls
    input wire logic soft_reset,
    input wire logic load_lo,
    input wire logic load_hi,
    input wire logic [3:0] nibble,
    input wire logic data_write,
    input wire logic data_read,
    input wire logic rmw_enter,
    input wire logic rmw_exit,
    // state out
    output logic [7:0] column_address,
    output logic rmw_active
);
    logic [7:0] col_reg;
    logic [7:0] col_next;
    logic [7:0] saved_reg;
    logic rmw_reg;

    // reads do not move the column while read-modify-write is on
    wire advance = data_write | (data_read & ~rmw_reg);
    wire [7:0] col_inc = (col_reg == `COLUMN_LAST) ? 8'h00 : col_reg + 8'h01;

    always_comb begin
        col_next = col_reg;
        if (soft_reset) begin
            col_next = `RST_COLUMN;
        end else if (rmw_exit && rmw_reg) begin
            col_next = saved_reg;
        end else if (load_lo) begin
            col_next = {col_reg[7:4], nibble};
        end else if (load_hi) begin
            col_next = {nibble, col_reg[3:0]};
        end else if (advance) begin
            col_next = col_inc;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_reg <= `RST_COLUMN;
            saved_reg <= `RST_COLUMN;
            rmw_reg <= 1'b0;
        end else begin
            col_reg <= col_next;
            if (soft_reset || rmw_exit) begin
                rmw_reg <= 1'b0;
            end else if (rmw_enter) begin
                rmw_reg <= 1'b1;
                saved_reg <= col_reg;
            end
        end
    end

    assign column_address = col_reg;
    assign rmw_active = rmw_reg;
endmodule // column_addr_unit

// [lcd_write_command_decoder.sv]
// write command interpreter of a dot-matrix lcd controller
// assumes host strobes are one clock wide and synchronous to clk
// Notes on behaviour
// - command when data/command select is low
// - 0000 prefix loads column low nibble, reset 0
// - 0001 prefix loads column high nibble, reset 0
// - 00100 prefix stores regulator gain, reset 100b
// - 00101 prefix sets buffer, regulator, booster enables
// - 01 prefix loads display start line
// - byte 81h then contrast byte, reset 20h
// - segment remap picks column 00h or 83h
// - bias bit picks 1/9 or 1/7
// - entire display on or normal
// - reverse video or normal
// - panel on or off, off after reset
// - 1011 prefix loads page address 0 to 8
// - 1100 prefix bit 3 reverses common scan
// - E0h enters read-modify-write, reads hold column
// - EEh exits, restoring column held at entry
// - E2h reinitialises all internal status registers
`timescale 1ns/1ps
`include "lcd_cmd_defines.svh"
module lcd_write_command_decoder
    import lcd_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host write port
    input wire logic wr_strobe,
    input wire logic dc_select,
    input wire logic [7:0] wr_byte,
    // host display data read
    input wire logic rd_strobe,
    // settings out
    output display_state_t settings,
    output logic [7:0] column_address,
    output logic rmw_active,
    output logic contrast_pending
);
    cmd_state_t state_reg;
    cmd_state_t state_next;
    display_state_t set_reg;
    display_state_t set_next;
    cmd_kind_t kind;

    // a low select marks a command byte, a high one display data
    wire cmd_taken = wr_strobe & ~dc_select;
    wire data_write = wr_strobe & dc_select;
    wire data_read = rd_strobe & dc_select;
    wire first_byte = cmd_taken & (state_reg == ST_IDLE);
    wire second_byte = cmd_taken & (state_reg == ST_WAIT_CONTRAST);
    wire soft_reset = first_byte & (kind == CMD_SOFT_RESET);

    localparam display_state_t SET_RESET = '{
        page_address: `RST_PAGE,
        start_line: `RST_START_LINE,
        contrast_level: `RST_CONTRAST,
        regulator_gain_select: `RST_GAIN,
        power_enable_bits: `RST_POWER,
        seg_remap: 1'b0,
        bias_alt: 1'b0,
        entire_on: 1'b0,
        reverse_video: 1'b0,
        display_on: 1'b0,
        com_reverse: 1'b0
    };

    cmd_byte_decode u_decode (
        .cmd_byte(wr_byte),
        .cmd_kind(kind)
    );

    column_addr_unit u_column (
        .clk(clk),
        .rst_n(rst_n),
        .soft_reset(soft_reset),
        .load_lo(first_byte && kind == CMD_COL_LO),
        .load_hi(first_byte && kind == CMD_COL_HI),
        .nibble(wr_byte[3:0]),
        .data_write(data_write),
        .data_read(data_read),
        .rmw_enter(first_byte && kind == CMD_RMW_ENTER),
        .rmw_exit(first_byte && kind == CMD_RMW_EXIT),
        .column_address(column_address),
        .rmw_active(rmw_active)
    );

    // second byte of the contrast pair is waited for across data writes
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (first_byte && kind == CMD_CONTRAST) begin
                    state_next = ST_WAIT_CONTRAST;
                end
            end
            ST_WAIT_CONTRAST: begin
                if (cmd_taken) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        set_next = set_reg;
        if (second_byte) begin
            set_next.contrast_level = wr_byte[5:0];
        end else if (first_byte) begin
            case (kind)
                CMD_GAIN: set_next.regulator_gain_select = wr_byte[2:0];
                CMD_POWER: set_next.power_enable_bits = wr_byte[2:0];
                CMD_START: set_next.start_line = wr_byte[5:0];
                CMD_SEG_REMAP: set_next.seg_remap = wr_byte[0];
                CMD_BIAS: set_next.bias_alt = wr_byte[0];
                CMD_ALL_ON: set_next.entire_on = wr_byte[0];
                CMD_REVERSE: set_next.reverse_video = wr_byte[0];
                CMD_DISP_ON: set_next.display_on = wr_byte[0];
                CMD_COM_DIR: set_next.com_reverse = wr_byte[3];
                CMD_SOFT_RESET: set_next = SET_RESET;
                CMD_PAGE: begin
                    // pages above the last one are ignored rather than wrapped
                    if (wr_byte[3:0] <= `PAGE_LAST) begin
                        set_next.page_address = wr_byte[3:0];
                    end
                end
                default: set_next = set_reg;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            set_reg <= SET_RESET;
        end else begin
            state_reg <= state_next;
            set_reg <= set_next;
        end
    end

    assign settings = set_reg;
    assign contrast_pending = (state_reg == ST_WAIT_CONTRAST);

    // helper for checking the restore on leaving read-modify-write
    logic [7:0] chk_entry_col;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_entry_col <= 8'h00;
        end else if (first_byte && kind == CMD_RMW_ENTER) begin
            chk_entry_col <= column_address;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_data_no_setting: assert property (
        (data_write && !contrast_pending) |=> $stable(settings))
        else $error("data write changed a setting");

    chk_col_lo_nibble: assert property (
        (first_byte && wr_byte[7:4] == 4'h0 && !data_read)
        |=> (column_address == {$past(column_address[7:4]), $past(wr_byte[3:0])}))
        else $error("low column nibble load wrong");

    chk_col_hi_nibble: assert property (
        (first_byte && wr_byte[7:4] == 4'h1 && !data_read)
        |=> (column_address == {$past(wr_byte[3:0]), $past(column_address[3:0])}))
        else $error("high column nibble load wrong");

    chk_gain_power_load: assert property (
        (first_byte && wr_byte[7:4] == 4'h2)
        |=> ($past(wr_byte[3]) ? settings.power_enable_bits : settings.regulator_gain_select) == $past(wr_byte[2:0]))
        else $error("gain or power load wrong");

    chk_start_line_load: assert property (
        (first_byte && wr_byte[7:6] == 2'b01) |=> settings.start_line == $past(wr_byte[5:0]))
        else $error("start line load wrong");

    chk_contrast_wait: assert property (
        (first_byte && wr_byte == 8'h81) |=> contrast_pending)
        else $error("contrast opcode not held for its value");

    chk_contrast_pair: assert property (
        second_byte
        |=> (settings.contrast_level == $past(wr_byte[5:0]) && !contrast_pending))
        else $error("contrast pair not stored");

    chk_mode_bits: assert property (
        (first_byte && wr_byte[7:1] == 7'h57) |=> settings.display_on == $past(wr_byte[0]))
        else $error("display on bit wrong");

    chk_page_range: assert property (
        (first_byte && wr_byte[7:4] == 4'hb)
        |=> settings.page_address == (($past(wr_byte[3:0]) <= 4'h8) ? $past(wr_byte[3:0])
                                     : $past(settings.page_address)))
        else $error("page address load wrong");

    chk_com_dir: assert property (
        (first_byte && wr_byte[7:4] == 4'hc) |=> settings.com_reverse == $past(wr_byte[3]))
        else $error("common scan direction wrong");

    chk_rmw_read_hold: assert property (
        (rmw_active && data_read && !cmd_taken && !data_write) |=> $stable(column_address))
        else $error("read moved column in read-modify-write");

    chk_rmw_restore: assert property (
        (first_byte && wr_byte == 8'hee && rmw_active)
        |=> (column_address == chk_entry_col && !rmw_active))
        else $error("column not restored on exit");

    chk_soft_reset_all: assert property (
        (first_byte && wr_byte == 8'he2)
        |=> (settings == SET_RESET && column_address == 8'h00 && !rmw_active))
        else $error("soft reset left state behind");

    cov_contrast_pair: cover property (contrast_pending ##1 !contrast_pending);
    cov_rmw_round: cover property (rmw_active ##[1:20] !rmw_active);
    cov_soft_reset: cover property (soft_reset);
    cov_column_wrap: cover property (column_address == 8'h83 && data_write);
endmodule // lcd_write_command_decoder

// [host_model.sv]
// host microcontroller model driving the command and data write port
// assumes each task call returns before the next one starts
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // host bus
    output logic wr_strobe,
    output logic dc_select,
    output logic [7:0] wr_byte,
    output logic rd_strobe
);
    initial begin
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        dc_select = 1'b1;
        wr_byte = 8'h5a;
    end

    // one strobe per byte, changed on the falling edge only
    task automatic write_byte(input logic dc, input logic [7:0] b);
        @(negedge clk);
        dc_select = dc;
        wr_byte = b;
        wr_strobe = 1'b1;
        @(negedge clk);
        wr_strobe = 1'b0;
        // a released bus must not keep showing the last value
        wr_byte = ~b;
    endtask

    task automatic read_data();
        @(negedge clk);
        dc_select = 1'b1;
        rd_strobe = 1'b1;
        @(negedge clk);
        rd_strobe = 1'b0;
    endtask

    // contrast is always sent whole: opcode, then value
    task automatic send_contrast(input logic [5:0] v);
        write_byte(1'b0, 8'h81);
        write_byte(1'b0, {2'b00, v});
    endtask
endmodule // host_model

// [tb_top.sv]
// self-checking bench for the write command interpreter
// assumes host_model drives the bus; outputs settle one cycle after a write
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end
module tb_top
    import lcd_cmd_pkg::*;
;
    logic clk;
    logic rst_n;
    logic wr_strobe;
    logic dc_select;
    logic [7:0] wr_byte;
    logic rd_strobe;
    display_state_t settings;
    logic [7:0] column_address;
    logic rmw_active;
    logic contrast_pending;
    int err_count = 0;
    int checks = 0;
    // page, start, contrast, gain, power, then six mode bits
    localparam display_state_t RST_STATE = '{4'h0, 6'h00, 6'h20, 3'h4, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    lcd_write_command_decoder i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .wr_strobe(wr_strobe),
        .dc_select(dc_select),
        .wr_byte(wr_byte),
        .rd_strobe(rd_strobe),
        .settings(settings),
        .column_address(column_address),
        .rmw_active(rmw_active),
        .contrast_pending(contrast_pending)
    );

    host_model i_host (
        .clk(clk),
        .wr_strobe(wr_strobe),
        .dc_select(dc_select),
        .wr_byte(wr_byte),
        .rd_strobe(rd_strobe)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic cmd(input logic [7:0] b);
        i_host.write_byte(1'b0, b);
    endtask

    task automatic set_col(input logic [7:0] c);
        cmd({4'h0, c[3:0]});
        cmd({4'h1, c[7:4]});
    endtask

    task automatic check_reset_state(input string where);
        `CHK(settings, RST_STATE, where)
        `CHK(column_address, 8'h00, where)
        `CHK(rmw_active, 1'b0, where)
        `CHK(contrast_pending, 1'b0, where)
    endtask

    task automatic t_column();
        set_col(8'h7a);
        `CHK(column_address, 8'h7a, "column nibbles")
        cmd(8'h03);
        `CHK(column_address, 8'h73, "low nibble only")
        cmd(8'h12);
        `CHK(column_address, 8'h23, "high nibble only")
    endtask

    task automatic t_fields();
        cmd(8'h27);
        `CHK(settings.regulator_gain_select, 3'h7, "gain max")
        cmd(8'h20);
        `CHK(settings.regulator_gain_select, 3'h0, "gain min")
        cmd(8'h2d);
        `CHK(settings.power_enable_bits, 3'h5, "power 5")
        cmd(8'h2a);
        `CHK(settings.power_enable_bits, 3'h2, "power 2")
        cmd(8'h7f);
        `CHK(settings.start_line, 6'h3f, "start 63")
        cmd(8'h40);
        `CHK(settings.start_line, 6'h00, "start 0")
        // same byte as data must not touch the power bits
        i_host.write_byte(1'b1, 8'h2f);
        `CHK(settings.power_enable_bits, 3'h2, "data not command")
    endtask

    task automatic t_contrast();
        set_col(8'h83);
        cmd(8'h81);
        `CHK(contrast_pending, 1'b1, "contrast waiting")
        i_host.write_byte(1'b1, 8'h00);
        `CHK(column_address, 8'h00, "data wraps column")
        `CHK(contrast_pending, 1'b1, "still waiting")
        cmd(8'he3);
        `CHK(settings.contrast_level, 6'h23, "contrast value")
        `CHK(contrast_pending, 1'b0, "contrast done")
        i_host.send_contrast(6'h3f);
        `CHK(settings.contrast_level, 6'h3f, "contrast max")
    endtask

    task automatic t_modes();
        logic [7:0] op [5] = '{8'ha0, 8'ha2, 8'ha4, 8'ha6, 8'hae};
        int idx [5] = '{5, 4, 3, 2, 1};
        for (int i = 0; i < 5; i++) begin
            cmd(op[i] | 8'h01);
            `CHK(settings[idx[i]], 1'b1, "mode set")
            cmd(op[i]);
            `CHK(settings[idx[i]], 1'b0, "mode clear")
        end
        cmd(8'hc8);
        `CHK(settings.com_reverse, 1'b1, "com reverse")
        cmd(8'hc7);
        `CHK(settings.com_reverse, 1'b0, "com normal")
    endtask

    task automatic t_page();
        cmd(8'hb8);
        `CHK(settings.page_address, 4'h8, "page 8")
        cmd(8'hb9);
        `CHK(settings.page_address, 4'h8, "page 9 ignored")
        cmd(8'hb0);
        `CHK(settings.page_address, 4'h0, "page 0")
    endtask

    task automatic t_rmw();
        set_col(8'h10);
        cmd(8'he0);
        `CHK(rmw_active, 1'b1, "rmw on")
        i_host.read_data();
        `CHK(column_address, 8'h10, "read holds column")
        i_host.write_byte(1'b1, 8'h00);
        `CHK(column_address, 8'h11, "write advances")
        cmd(8'hee);
        `CHK(column_address, 8'h10, "column restored")
        `CHK(rmw_active, 1'b0, "rmw off")
        i_host.read_data();
        `CHK(column_address, 8'h11, "read advances")
    endtask

    task automatic t_soft_reset();
        cmd(8'h21);
        cmd(8'hb2);
        cmd(8'haf);
        i_host.send_contrast(6'h15);
        set_col(8'h40);
        cmd(8'he0);
        cmd(8'h81);
        // the byte after 81h is the contrast value whatever its pattern
        cmd(8'he2);
        `CHK(settings.contrast_level, 6'h22, "e2 taken as contrast")
        cmd(8'he2);
        check_reset_state("after soft reset");
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check_reset_state("after power on");
        t_column();
        t_fields();
        t_contrast();
        t_modes();
        t_page();
        t_rmw();
        t_soft_reset();
        tally_and_finish();
    end
endmodule // tb_top
